// file: rtl/expint_defs.vh
`ifndef EXPINT_DEFS_VH
`define EXPINT_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EXPINT_IDX_ENABLE_MASK 10'h01D
`define EXPINT_IDX_FLAGS 10'h01C
`define EXPINT_IDX_SENSE_CTRL 10'h069
`define EXPINT_IDX_CHG_ENABLE 10'h068
`define EXPINT_IDX_CHG_FLAGS 10'h01B
`define EXPINT_IDX_CHG_MASK0 10'h06B
`define EXPINT_IDX_CHG_MASK1 10'h06C
`define EXPINT_IDX_CHG_MASK2 10'h06D

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EXPINT_RST_ENABLE_MASK 2'h0
`define EXPINT_RST_SENSE_CTRL 4'h0
`define EXPINT_RST_FLAGS 2'h0
`define EXPINT_RST_CHG_ENABLE 3'h0
`define EXPINT_RST_CHG_FLAGS 3'h0
`define EXPINT_RST_CHG_MASK 8'h00

// ----------------------------------------------------------------
// sense field encodings and layout
// ----------------------------------------------------------------
`define EXPINT_SENSE_W 2
`define EXPINT_SENSE_LOW 2'h0
`define EXPINT_SENSE_ANY 2'h1
`define EXPINT_SENSE_FALL 2'h2
`define EXPINT_SENSE_RISE 2'h3
`define EXPINT_SENSE1_LSB 2
`define EXPINT_SENSE0_LSB 0

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define EXPINT_EXT_LINES 2
`define EXPINT_BANKS 3
`define EXPINT_BANK_W 8
`define EXPINT_BANK1_USED 8'h7F

`endif

// file: rtl/expint_top.v
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
// How it works
// - interrupts fire from pin level even when the pin is driven as an output.
// - bank 2 request on any unmasked toggle of change lines 23..16 with enable and global flag.
// - bank 1 request on any unmasked toggle of change lines 14..8 with enable and global flag.
// - bank 0 request on unmasked change of lines 7..0 with enable and global flag.
// - pin-change wake detect works without the I/O clock.
// - low-level mode requests continuously while the pin stays low.
// - edges on dedicated pins are seen only while the I/O clock runs.
// - low level on a dedicated pin is detected without a clock for wake-up.
// - I/O clock stops in sleep modes except idle, so edges are not seen.
// - level gone before start-up ends gives wake but no interrupt.
// - sense bits 3..2 pick line one mode: low, any, fall, rise.
// - sense bits 1..0 pick line zero mode with the same encodings.
// - dedicated pins are sampled first; pulses over one clock give a request.
// - dedicated interrupt needs its enable bit and the global enable flag.
// - unused bits of sense, enable and flag registers read zero.
// - flag bit 1 or bit 0 sets on a triggering edge or change.
// - flag clears on vector entry or a one written to it.
// - flag is held cleared while its line is in level mode.
// - each dedicated interrupt has its own vector, apart from banks.
// - each change line has its own mask bit; masked lines never contribute.
// - per-bank flag sets on change, clears on vector entry or write one.
`include "expint_defs.vh"

module expint_top #(
	parameter ADDR_W = 12
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [ADDR_W-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,
	input wire [1:0] ext_lines_in,
	input wire [23:0] change_inputs_all_in,
	input wire cpu_status_word_ie_in,
	input wire io_clk_run_in,
	input wire [1:0] ext_vector_ack_in,
	input wire [2:0] change_vector_ack_in,
	output wire [1:0] ext_irq_req_out,
	output wire [2:0] change_irq_req_out,
	output wire wake_req_out
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function edge_hit;
		input [1:0] mode;
		input rise;
		input fall;
		begin
			case (mode)
				`EXPINT_SENSE_ANY: edge_hit = rise | fall;
				`EXPINT_SENSE_FALL: edge_hit = fall;
				`EXPINT_SENSE_RISE: edge_hit = rise;
				default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	function is_level;
		input [1:0] mode;
		begin
			is_level = (mode == `EXPINT_SENSE_LOW);
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [1:0] enable_mask_reg;
	reg [3:0] sense_ctrl_reg;
	reg [1:0] flags_reg;
	reg [1:0] flags_next;
	reg [2:0] chg_enable_reg;
	reg [2:0] chg_flags_reg;
	reg [2:0] chg_flags_next;
	reg [23:0] chg_mask_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;
	reg [25:0] sync1_reg;
	reg [25:0] sync2_reg;
	reg [25:0] prev_reg;

	wire [9:0] idx;
	wire setup_ph;
	wire wr_acc;
	wire hit_any;
	wire [1:0] ext_s;
	wire [1:0] ext_p;
	wire [23:0] chg_s;
	wire [23:0] chg_p;
	wire [23:0] chg_delta;
	wire [2:0] bank_hit;
	wire [1:0] ext_event;
	wire [1:0] ext_level_req;
	wire [1:0] ext_level_wake;
	wire [23:0] chg_async;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign idx = paddr_in[11:2];
	assign setup_ph = psel_in & ~penable_in;
	assign wr_acc = psel_in & penable_in & pwrite_in;
	assign hit_any = (idx == `EXPINT_IDX_ENABLE_MASK) | (idx == `EXPINT_IDX_FLAGS) |
		(idx == `EXPINT_IDX_SENSE_CTRL) | (idx == `EXPINT_IDX_CHG_ENABLE) |
		(idx == `EXPINT_IDX_CHG_FLAGS) | (idx == `EXPINT_IDX_CHG_MASK0) |
		(idx == `EXPINT_IDX_CHG_MASK1) | (idx == `EXPINT_IDX_CHG_MASK2);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~hit_any;
	assign prdata_out = rdata_reg;

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			sync1_reg <= 26'h0000000;
			sync2_reg <= 26'h0000000;
			prev_reg <= 26'h0000000;
		end else begin
			// pin level is read even when the port drives it
			sync1_reg <= {ext_lines_in, change_inputs_all_in};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign ext_s = sync2_reg[25:24];
	assign ext_p = prev_reg[25:24];
	assign chg_s = sync2_reg[23:0];
	assign chg_p = prev_reg[23:0];
	assign chg_delta = (chg_s ^ chg_p) & chg_mask_reg;

	// ----------------------------------------------------------------
	// dedicated lines
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `EXPINT_EXT_LINES; gi = gi + 1) begin : g_ext
			wire [1:0] mode;
			assign mode = sense_ctrl_reg[2*gi+1:2*gi];
			// edges only counted while the io clock runs
			assign ext_event[gi] = io_clk_run_in &
				edge_hit(mode, ext_s[gi] & ~ext_p[gi], ~ext_s[gi] & ext_p[gi]);
			// level request follows the pin, so a vanished level gives none
			assign ext_level_req[gi] = is_level(mode) & ~ext_s[gi];
			// asynchronous low detect for wake
			assign ext_level_wake[gi] = enable_mask_reg[gi] & is_level(mode) &
				~ext_lines_in[gi];
			// own vector per line
			assign ext_irq_req_out[gi] = cpu_status_word_ie_in & enable_mask_reg[gi] &
				(ext_level_req[gi] | flags_reg[gi]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// change banks
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < `EXPINT_BANKS; gi = gi + 1) begin : g_bank
			assign bank_hit[gi] = |chg_delta[8*gi+7:8*gi];
			// own vector per bank, gated by bank enable and global flag
			assign change_irq_req_out[gi] = cpu_status_word_ie_in & chg_enable_reg[gi] &
				chg_flags_reg[gi];
		end
	endgenerate

	// unclocked compare against last sample for wake
	assign chg_async = (change_inputs_all_in ^ chg_p) & chg_mask_reg &
		{{8{chg_enable_reg[2]}}, {8{chg_enable_reg[1]}}, {8{chg_enable_reg[0]}}};
	assign wake_req_out = (|chg_async) | (|ext_level_wake);

	// ----------------------------------------------------------------
	// flag next state
	// ----------------------------------------------------------------
	always @* begin
		flags_next = flags_reg;
		chg_flags_next = chg_flags_reg;
		if (wr_acc && idx == `EXPINT_IDX_FLAGS) begin
			flags_next = flags_next & ~pwdata_in[1:0];
		end
		flags_next = flags_next & ~ext_vector_ack_in;
		flags_next = flags_next | ext_event;
		if (is_level(sense_ctrl_reg[1:0])) begin
			flags_next[0] = 1'b0;
		end
		if (is_level(sense_ctrl_reg[3:2])) begin
			flags_next[1] = 1'b0;
		end
		if (wr_acc && idx == `EXPINT_IDX_CHG_FLAGS) begin
			chg_flags_next = chg_flags_next & ~pwdata_in[2:0];
		end
		chg_flags_next = (chg_flags_next & ~change_vector_ack_in) | bank_hit;
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			enable_mask_reg <= `EXPINT_RST_ENABLE_MASK;
			sense_ctrl_reg <= `EXPINT_RST_SENSE_CTRL;
			flags_reg <= `EXPINT_RST_FLAGS;
			chg_enable_reg <= `EXPINT_RST_CHG_ENABLE;
			chg_flags_reg <= `EXPINT_RST_CHG_FLAGS;
			chg_mask_reg <= {3{`EXPINT_RST_CHG_MASK}};
		end else begin
			flags_reg <= flags_next;
			chg_flags_reg <= chg_flags_next;
			if (wr_acc) begin
				case (idx)
					`EXPINT_IDX_ENABLE_MASK: enable_mask_reg <= pwdata_in[1:0];
					`EXPINT_IDX_SENSE_CTRL: sense_ctrl_reg <= pwdata_in[3:0];
					`EXPINT_IDX_CHG_ENABLE: chg_enable_reg <= pwdata_in[2:0];
					`EXPINT_IDX_CHG_MASK0: chg_mask_reg[7:0] <= pwdata_in[7:0];
					`EXPINT_IDX_CHG_MASK1: chg_mask_reg[15:8] <= pwdata_in[7:0] &
						`EXPINT_BANK1_USED;
					`EXPINT_IDX_CHG_MASK2: chg_mask_reg[23:16] <= pwdata_in[7:0];
					default: chg_mask_reg <= chg_mask_reg;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// read data, captured in the setup phase
	// ----------------------------------------------------------------
	always @* begin
		rdata_next = 32'h00000000;
		case (idx)
			`EXPINT_IDX_ENABLE_MASK: rdata_next[1:0] = enable_mask_reg;
			`EXPINT_IDX_SENSE_CTRL: rdata_next[3:0] = sense_ctrl_reg;
			`EXPINT_IDX_FLAGS: rdata_next[1:0] = flags_reg;
			`EXPINT_IDX_CHG_ENABLE: rdata_next[2:0] = chg_enable_reg;
			`EXPINT_IDX_CHG_FLAGS: rdata_next[2:0] = chg_flags_reg;
			`EXPINT_IDX_CHG_MASK0: rdata_next[7:0] = chg_mask_reg[7:0];
			`EXPINT_IDX_CHG_MASK1: rdata_next[7:0] = chg_mask_reg[15:8];
			`EXPINT_IDX_CHG_MASK2: rdata_next[7:0] = chg_mask_reg[23:16];
			default: rdata_next = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			rdata_reg <= 32'h00000000;
		end else if (setup_ph) begin
			rdata_reg <= rdata_next;
		end
	end

endmodule // expint_top

// file: verification/expint_src.sv
`timescale 1ns/100ps
// ----------------------------------
// off-chip sources on the pins
// ----------------------------------
module expint_src (
	input wire clk_sys_in,
	output logic [1:0] ext_lines_out,
	output logic [23:0] change_inputs_out
);
	initial begin
		ext_lines_out = 2'h3;
		change_inputs_out = 24'h000000;
	end
	// callers hold each level two clocks or more, past one instruction
	task automatic set_ext(input logic [1:0] v);
		@(posedge clk_sys_in) ext_lines_out <= v;
	endtask
	task automatic flip_chg(input logic [23:0] m);
		@(posedge clk_sys_in) change_inputs_out <= change_inputs_out ^ m;
	endtask
endmodule // expint_src

// file: verification/expint_props.sv
`timescale 1ns/100ps
`include "expint_defs.vh"
// ------------------------------
// port checks
// ------------------------------
module expint_props #(
	parameter ADDR_W = 12
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [ADDR_W-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire pslverr_out,
	input wire [1:0] ext_lines_in,
	input wire cpu_status_word_ie_in,
	input wire io_clk_run_in,
	input wire [1:0] ext_irq_req_out,
	input wire [2:0] change_irq_req_out
);
	logic [1:0] en_reg;
	logic [3:0] sense_reg;
	wire acc = psel_in && penable_in;
	wire on0 = en_reg[0] && cpu_status_word_ie_in;
	wire lvl0 = on0 && sense_reg[1:0] == `EXPINT_SENSE_LOW;
	wire arm0 = on0 && io_clk_run_in && sense_reg[1:0] == `EXPINT_SENSE_RISE;
	// shadow of enable and sense registers
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			en_reg <= 2'h0;
			sense_reg <= 4'h0;
		end else if (acc && pwrite_in) begin
			if (paddr_in == {`EXPINT_IDX_ENABLE_MASK, 2'h0})
				en_reg <= pwdata_in[1:0];
			if (paddr_in == {`EXPINT_IDX_SENSE_CTRL, 2'h0})
				sense_reg <= pwdata_in[3:0];
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	chk_gie_ext: assert property (|ext_irq_req_out |-> cpu_status_word_ie_in)
		else $error("line request without global enable");
	chk_gie_chg: assert property (|change_irq_req_out |-> cpu_status_word_ie_in)
		else $error("bank request without global enable");
	chk_level_req: assert property ((!ext_lines_in[0] && lvl0)[*3] |-> ext_irq_req_out[0])
		else $error("low level gives no request");
	chk_level_drop: assert property ((ext_lines_in[0] && sense_reg[1:0] == 2'h0)[*3]
		|-> !ext_irq_req_out[0]) else $error("level mode request with pin high");
	chk_rise_req: assert property ($rose(ext_lines_in[0]) && arm0
		##1 (ext_lines_in[0] && arm0)[*2] |=> ext_irq_req_out[0]) else $error("rise missed");
	chk_sense_zero: assert property (acc && !pwrite_in
		&& paddr_in == {`EXPINT_IDX_SENSE_CTRL, 2'h0} |-> prdata_out[31:4] == 28'h0)
		else $error("sense upper bits not zero");
	chk_mask_zero: assert property (acc && !pwrite_in
		&& paddr_in == {`EXPINT_IDX_ENABLE_MASK, 2'h0} |-> prdata_out[31:2] == 30'h0)
		else $error("enable upper bits not zero");
	chk_err_phase: assert property (pslverr_out |-> acc)
		else $error("error outside access phase");
	cover property (lvl0 && ext_irq_req_out[0]);
	cover property (|change_irq_req_out);
	cover property (pslverr_out);
endmodule // expint_props

// file: verification/test_expint_top.sv
`timescale 1ns/100ps
`include "expint_defs.vh"
// ------------------------------
// bench
// ------------------------------
module test_expint_top;
	localparam logic [11:0] AEN = {`EXPINT_IDX_ENABLE_MASK, 2'h0};
	localparam logic [11:0] ASNS = {`EXPINT_IDX_SENSE_CTRL, 2'h0};
	localparam logic [11:0] AFLG = {`EXPINT_IDX_FLAGS, 2'h0};
	localparam logic [11:0] ACEN = {`EXPINT_IDX_CHG_ENABLE, 2'h0};
	localparam logic [11:0] ACFL = {`EXPINT_IDX_CHG_FLAGS, 2'h0};
	localparam logic [11:0] AMSK = {`EXPINT_IDX_CHG_MASK0, 2'h0};
	logic clk_sys_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
	logic pwrite_in = 1'b0, ie = 1'b0, io_run = 1'b1, pready_out, pslverr_out, wake, rd_err;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd_data;
	logic [1:0] ext_ack = 2'h0, ext_lines_in, ext_irq_req_out;
	logic [2:0] chg_ack = 3'h0, change_irq_req_out;
	logic [23:0] chg_in;
	int mismatches = 0, checked = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	expint_src u_expint_src (.clk_sys_in(clk_sys_in), .ext_lines_out(ext_lines_in),
		.change_inputs_out(chg_in));
	expint_top u_expint_top (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .ext_lines_in(ext_lines_in), .change_inputs_all_in(chg_in),
		.cpu_status_word_ie_in(ie), .io_clk_run_in(io_run), .ext_vector_ack_in(ext_ack),
		.change_vector_ack_in(chg_ack), .ext_irq_req_out(ext_irq_req_out),
		.change_irq_req_out(change_irq_req_out), .wake_req_out(wake));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		{psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, wr, a, d};
		@(posedge clk_sys_in) penable_in <= 1'b1;
		do @(posedge clk_sys_in); while (pready_out !== 1'b1);
		rd_data = prdata_out;
		rd_err = pslverr_out;
		{psel_in, penable_in} <= 2'h0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd_data, exp);
	endtask
	function automatic logic fe(input logic [1:0] m, input logic r);
		return m == `EXPINT_SENSE_ANY || m == (r ? `EXPINT_SENSE_RISE : `EXPINT_SENSE_FALL);
	endfunction
	task automatic t_regs();
		rdc(AEN, 32'h0);
		apb(1'b1, ASNS, 32'hFFFFFFFF);
		rdc(ASNS, 32'hF);
		apb(1'b1, AMSK + 12'h4, 32'hFF);
		rdc(AMSK + 12'h4, 32'h7F);
		rdc(12'hFFC, 32'h0);
		chk(rd_err, 32'h1);
	endtask
	task automatic t_modes();
		logic [1:0] m0, m1;
		apb(1'b1, AEN, 32'h3);
		ie <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			m0 = m[1:0];
			m1 = 2'h3 - m0;
			apb(1'b1, ASNS, {28'h0, m1, m0});
			apb(1'b1, AFLG, 32'h3);
			u_expint_src.set_ext(2'h0);
			w(4);
			chk(ext_irq_req_out, {fe(m1, 0) | m1 == 0, fe(m0, 0) | m0 == 0});
			rdc(AFLG, {fe(m1, 0), fe(m0, 0)});
			apb(1'b1, AFLG, 32'h3);
			rdc(AFLG, 32'h0);
			u_expint_src.set_ext(2'h3);
			w(4);
			rdc(AFLG, {fe(m1, 1), fe(m0, 1)});
		end
	endtask
	task automatic t_gie();
		apb(1'b1, ASNS, 32'hF);
		apb(1'b1, AFLG, 32'h3);
		ie <= 1'b0;
		u_expint_src.set_ext(2'h2);
		w(2);
		u_expint_src.set_ext(2'h3);
		w(4);
		chk(ext_irq_req_out, 32'h0);
		@(posedge clk_sys_in) ie <= 1'b1;
		w(1);
		chk({change_irq_req_out, ext_irq_req_out}, 32'h1);
		@(posedge clk_sys_in) ext_ack <= 2'h1;
		@(posedge clk_sys_in) ext_ack <= 2'h0;
		rdc(AFLG, 32'h0);
	endtask
	task automatic t_sleep();
		apb(1'b1, ASNS, 32'h0);
		io_run <= 1'b0;
		u_expint_src.set_ext(2'h2);
		w(1);
		chk(wake, 32'h1);
		u_expint_src.set_ext(2'h3);
		@(posedge clk_sys_in) io_run <= 1'b1;
		w(4);
		chk(ext_irq_req_out, 32'h0);
		apb(1'b1, ASNS, 32'hF);
		io_run <= 1'b0;
		u_expint_src.set_ext(2'h0);
		w(2);
		u_expint_src.set_ext(2'h3);
		w(4);
		@(posedge clk_sys_in) io_run <= 1'b1;
		rdc(AFLG, 32'h0);
	endtask
	task automatic t_change();
		apb(1'b1, ACEN, 32'h7);
		for (int b = 0; b < 3; b++) begin
			apb(1'b1, AMSK + 12'(4 * b), 32'h1);
			u_expint_src.flip_chg(24'h2 << (8 * b));
			w(4);
			rdc(ACFL, 32'h0);
			u_expint_src.flip_chg(24'h1 << (8 * b));
			w(4);
			chk(change_irq_req_out, 32'h1 << b);
			@(posedge clk_sys_in) chg_ack <= 3'(1 << b);
			@(posedge clk_sys_in) chg_ack <= 3'h0;
			rdc(ACFL, 32'h0);
			u_expint_src.flip_chg(24'h1 << (8 * b));
			w(4);
			chk(change_irq_req_out, 32'h1 << b);
			apb(1'b1, ACFL, 32'h1 << b);
			rdc(ACFL, 32'h0);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_regs();
		t_modes();
		t_gie();
		t_sleep();
		t_change();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		complete_run();
	end
endmodule // test_expint_top
bind expint_top expint_props #(.ADDR_W(ADDR_W)) u_expint_props (.clk_sys_in(clk_sys_in),
	.reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pslverr_out(pslverr_out), .ext_lines_in(ext_lines_in),
	.cpu_status_word_ie_in(cpu_status_word_ie_in), .io_clk_run_in(io_clk_run_in),
	.ext_irq_req_out(ext_irq_req_out), .change_irq_req_out(change_irq_req_out));
